// File: src/sip_pkg.sv
// package: register map and constants for the shared io port
package sip_pkg;
  localparam int unsigned PIN_W = 16;
  localparam int unsigned CN_W  = 31;
  localparam logic [PIN_W-1:0] IMPL_MASK = 16'hFFFF;
  localparam logic [7:0] OFF_DIR    = 8'h00;
  localparam logic [7:0] OFF_PORT   = 8'h04;
  localparam logic [7:0] OFF_LAT    = 8'h08;
  localparam logic [7:0] OFF_ODC    = 8'h0C;
  localparam logic [7:0] OFF_ANA    = 8'h10;
  localparam logic [7:0] OFF_CNEN_L = 8'h14;
  localparam logic [7:0] OFF_CNEN_H = 8'h18;
  localparam logic [7:0] OFF_CNPU_L = 8'h1C;
  localparam logic [7:0] OFF_CNPU_H = 8'h20;
  localparam logic [7:0] OFF_STAT   = 8'h24;
  localparam logic [7:0] OFF_MASK   = 8'h28;
  localparam logic [PIN_W-1:0] RST_DIR = 16'hFFFF;
  localparam logic [PIN_W-1:0] RST_ZERO = 16'h0000;
  localparam logic [CN_W-1:0]  RST_CN   = 31'h00000000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : sip_pkg

// File: src/sip_port.sv
// module: shared io port with change notification, ahb-lite slave
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - active peripheral drive disables port driver; pin still readable
// - enabled but idle peripheral lets port drive the pin
// - port output never loops into the sharing peripheral input
// - direction bit one is input, zero is output
// - reset makes every pin an input
// - latch register reads and writes the latch
// - pin register reads pins; writes go to the latch
// - unimplemented bits read zero in latch, direction and pin
// - input-only shared pin acts as dedicated port pin
// - open-drain bit makes that pin's port output open-drain; peripheral drive ignores it
// - analog-configured pins read low from pin register
// - selected input pin change raises interrupt request
// - change detection works without clock in sleep
// - up to 31 change inputs, each selectable
// - two change interrupt enable registers, bit per pin
// - two pull-up enable registers enable weak pull-ups
module sip_port
  import sip_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic [sip_pkg::PIN_W-1:0] pin_in,
  output logic      [sip_pkg::PIN_W-1:0] pin_out,
  output logic      [sip_pkg::PIN_W-1:0] pin_oe_n,
  input  wire logic [sip_pkg::PIN_W-1:0] periph_en,
  input  wire logic [sip_pkg::PIN_W-1:0] periph_drive,
  input  wire logic [sip_pkg::PIN_W-1:0] periph_out,
  output logic      [sip_pkg::PIN_W-1:0] periph_in,
  input  wire logic [sip_pkg::CN_W-1:0]  change_notify_pin,
  output logic      [sip_pkg::CN_W-1:0]  pull_up_en,
  output logic                         cn_async_req,
  output logic                         irq
);
  import sip_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] pin_direction_reg;
    logic [PIN_W-1:0] output_latch_reg;
    logic [PIN_W-1:0] open_drain_ctrl_reg;
    logic [PIN_W-1:0] analog_pin_config_reg;
    logic [15:0]      change_irq_enable_low;
    logic [14:0]      change_irq_enable_high;
    logic [15:0]      pull_up_enable_low;
    logic [14:0]      pull_up_enable_high;
    logic             stat;
    logic             mask;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [CN_W-1:0]  cn_s1;
    logic [CN_W-1:0]  cn_s2;
    logic [CN_W-1:0]  cn_prev;
    logic             dp_wr;
    logic             dp_rd;
    logic [7:0]       dp_addr;
    logic [31:0]      rdata;
  } sip_state_s;

  sip_state_s st;
  sip_state_s next_st;

  logic [CN_W-1:0]  cn_en;
  logic [CN_W-1:0]  cn_chg;
  logic [PIN_W-1:0] port_drv;
  logic [PIN_W-1:0] port_rd;
  logic             ap_take;
  logic             stat_rd;

  function automatic logic [31:0] zx16(input logic [PIN_W-1:0] v);
    zx16 = {16'h0000, v & IMPL_MASK};
  endfunction : zx16

  assign cn_en = {st.change_irq_enable_high, st.change_irq_enable_low};
  assign pull_up_en = {st.pull_up_enable_high, st.pull_up_enable_low};
  // unclocked compare: raw pin against captured level, for sleep wake
  assign cn_async_req = |((change_notify_pin ^ st.cn_prev) & cn_en);
  assign cn_chg = (st.cn_s2 ^ st.cn_prev) & cn_en;

  // per pin output mux
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_pin
      always_comb begin
        port_drv[gi] = ~st.pin_direction_reg[gi];
        if (periph_en[gi] && periph_drive[gi]) begin
          pin_out[gi]  = periph_out[gi];
          pin_oe_n[gi] = 1'b0;
        end else begin
          pin_out[gi]  = st.output_latch_reg[gi] & IMPL_MASK[gi];
          pin_oe_n[gi] = ~(port_drv[gi] & IMPL_MASK[gi]
            & ~(st.open_drain_ctrl_reg[gi] & st.output_latch_reg[gi]));
        end
        // port-driven level kept off the peripheral input
        periph_in[gi] = (port_drv[gi] && !(periph_en[gi] && periph_drive[gi]))
          ? 1'b0 : st.pin_s2[gi];
        port_rd[gi] = st.pin_s2[gi] & ~st.analog_pin_config_reg[gi];
      end
    end
  endgenerate

  assign ap_take  = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign stat_rd  = st.dp_rd && (st.dp_addr == OFF_STAT);
  assign hrdata   = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp    = 1'b0;
  assign irq      = st.stat & st.mask;

  always_comb begin
    next_st        = st;
    next_st.pin_s1 = pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.cn_s1  = change_notify_pin;
    next_st.cn_s2  = st.cn_s1;
    next_st.cn_prev = st.cn_s2;
    next_st.dp_wr  = ap_take && hwrite;
    next_st.dp_rd  = ap_take && !hwrite;
    next_st.dp_addr = ap_take ? haddr[7:0] : st.dp_addr;
    if (st.dp_wr) begin
      if (st.dp_addr == OFF_DIR) begin
        next_st.pin_direction_reg = hwdata[PIN_W-1:0];
      end else if (st.dp_addr == OFF_PORT || st.dp_addr == OFF_LAT) begin
        next_st.output_latch_reg = hwdata[PIN_W-1:0];
      end else if (st.dp_addr == OFF_ODC) begin
        next_st.open_drain_ctrl_reg = hwdata[PIN_W-1:0];
      end else if (st.dp_addr == OFF_ANA) begin
        next_st.analog_pin_config_reg = hwdata[PIN_W-1:0];
      end else if (st.dp_addr == OFF_CNEN_L) begin
        next_st.change_irq_enable_low = hwdata[15:0];
      end else if (st.dp_addr == OFF_CNEN_H) begin
        next_st.change_irq_enable_high = hwdata[14:0];
      end else if (st.dp_addr == OFF_CNPU_L) begin
        next_st.pull_up_enable_low = hwdata[15:0];
      end else if (st.dp_addr == OFF_CNPU_H) begin
        next_st.pull_up_enable_high = hwdata[14:0];
      end else if (st.dp_addr == OFF_MASK) begin
        next_st.mask = hwdata[0];
      end
    end
    next_st.rdata = 32'h00000000;
    if (ap_take && !hwrite) begin
      if (haddr[7:0] == OFF_DIR) begin
        next_st.rdata = zx16(st.pin_direction_reg);
      end else if (haddr[7:0] == OFF_PORT) begin
        next_st.rdata = zx16(port_rd);
      end else if (haddr[7:0] == OFF_LAT) begin
        next_st.rdata = zx16(st.output_latch_reg);
      end else if (haddr[7:0] == OFF_ODC) begin
        next_st.rdata = zx16(st.open_drain_ctrl_reg);
      end else if (haddr[7:0] == OFF_ANA) begin
        next_st.rdata = zx16(st.analog_pin_config_reg);
      end else if (haddr[7:0] == OFF_CNEN_L) begin
        next_st.rdata = {16'h0000, st.change_irq_enable_low};
      end else if (haddr[7:0] == OFF_CNEN_H) begin
        next_st.rdata = {17'h00000, st.change_irq_enable_high};
      end else if (haddr[7:0] == OFF_CNPU_L) begin
        next_st.rdata = {16'h0000, st.pull_up_enable_low};
      end else if (haddr[7:0] == OFF_CNPU_H) begin
        next_st.rdata = {17'h00000, st.pull_up_enable_high};
      end else if (haddr[7:0] == OFF_STAT) begin
        next_st.rdata = {31'h00000000, st.stat};
      end else if (haddr[7:0] == OFF_MASK) begin
        next_st.rdata = {31'h00000000, st.mask};
      end
    end
    // read clears; a new change wins over the clear
    if (stat_rd) begin
      next_st.stat = 1'b0;
    end
    if (|cn_chg) begin
      next_st.stat = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.pin_direction_reg <= RST_DIR;
    end else begin
      st <= next_st;
    end
  end

  property p_reset_inputs;
    @(posedge core_clk) $rose(resetn) |->
      (pin_oe_n | (periph_en & periph_drive)) == 16'hFFFF;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("direction not input after reset");

  property p_periph_wins;
    @(posedge core_clk) disable iff (!resetn)
      (periph_en[0] && periph_drive[0]) |->
        (!pin_oe_n[0] && pin_out[0] == periph_out[0]);
  endproperty
  a_periph_wins: assert property (p_periph_wins)
    else $error("peripheral not driving pin");

  property p_port_drives;
    @(posedge core_clk) disable iff (!resetn)
      (!periph_drive[0] && !st.pin_direction_reg[0]
        && !st.open_drain_ctrl_reg[0]) |-> !pin_oe_n[0];
  endproperty
  a_port_drives: assert property (p_port_drives)
    else $error("port output not driven");

  property p_no_loop;
    @(posedge core_clk) disable iff (!resetn)
      (!st.pin_direction_reg[0] && !periph_drive[0]) |-> !periph_in[0];
  endproperty
  a_no_loop: assert property (p_no_loop)
    else $error("loop through to peripheral");

  property p_input_dir;
    @(posedge core_clk) disable iff (!resetn)
      (st.pin_direction_reg[0] && !periph_drive[0]) |-> pin_oe_n[0];
  endproperty
  a_input_dir: assert property (p_input_dir)
    else $error("input pin driven");

  property p_open_drain;
    @(posedge core_clk) disable iff (!resetn)
      (!periph_drive[0] && st.open_drain_ctrl_reg[0]
        && st.output_latch_reg[0]) |-> pin_oe_n[0];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drives high");

  property p_analog_low;
    @(posedge core_clk) disable iff (!resetn)
      (ap_take && !hwrite && haddr[7:0] == OFF_PORT
        && (|st.analog_pin_config_reg)) |=>
        (hrdata[PIN_W-1:0] & $past(st.analog_pin_config_reg)) == 16'h0000;
  endproperty
  a_analog_low: assert property (p_analog_low)
    else $error("analog pin read high");

  sequence s_lat_write;
    st.dp_wr && (st.dp_addr == OFF_PORT);
  endsequence
  property p_port_write_latch;
    @(posedge core_clk) disable iff (!resetn)
      s_lat_write |=> st.output_latch_reg == $past(hwdata[PIN_W-1:0]);
  endproperty
  a_port_write_latch: assert property (p_port_write_latch)
    else $error("pin register write missed latch");

  sequence s_change;
    |cn_chg;
  endsequence
  property p_change_irq;
    @(posedge core_clk) disable iff (!resetn)
      (s_change and st.mask) |=> irq;
  endproperty
  a_change_irq: assert property (p_change_irq)
    else $error("change did not raise irq");

  property p_upper_zero;
    @(posedge core_clk) disable iff (!resetn)
      st.dp_rd |-> hrdata[31:17] == 15'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");

  property p_dir_reset_value;
    @(posedge core_clk)
      $rose(resetn) |-> st.pin_direction_reg == RST_DIR;
  endproperty
  a_dir_reset_value: assert property (p_dir_reset_value)
    else $error("direction register not all inputs");

  property p_lat_write;
    @(posedge core_clk) disable iff (!resetn)
      (st.dp_wr && st.dp_addr == OFF_LAT) |=>
        st.output_latch_reg == $past(hwdata[PIN_W-1:0]);
  endproperty
  a_lat_write: assert property (p_lat_write)
    else $error("latch write lost");

  property p_lat_read;
    @(posedge core_clk) disable iff (!resetn)
      (ap_take && !hwrite && haddr[7:0] == OFF_LAT) |=>
        hrdata == {16'h0000, $past(st.output_latch_reg)};
  endproperty
  a_lat_read: assert property (p_lat_read)
    else $error("latch read wrong");

  property p_port_read;
    @(posedge core_clk) disable iff (!resetn)
      (ap_take && !hwrite && haddr[7:0] == OFF_PORT) |=>
        hrdata[PIN_W-1:0] == $past(st.pin_s2 & ~st.analog_pin_config_reg);
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("pin read wrong");

  property p_periph_all;
    @(posedge core_clk) disable iff (!resetn)
      ((pin_oe_n | (pin_out ^ periph_out)) & periph_en & periph_drive)
        == 16'h0000;
  endproperty
  a_periph_all: assert property (p_periph_all)
    else $error("peripheral lost a pin");

  property p_no_loop_all;
    @(posedge core_clk) disable iff (!resetn)
      (~st.pin_direction_reg & ~(periph_en & periph_drive) & periph_in)
        == 16'h0000;
  endproperty
  a_no_loop_all: assert property (p_no_loop_all)
    else $error("port output seen by peripheral");

  property p_input_all;
    @(posedge core_clk) disable iff (!resetn)
      (st.pin_direction_reg & ~(periph_en & periph_drive) & ~pin_oe_n)
        == 16'h0000;
  endproperty
  a_input_all: assert property (p_input_all)
    else $error("input pin driven by port");

  property p_odc_all;
    @(posedge core_clk) disable iff (!resetn)
      (st.open_drain_ctrl_reg & st.output_latch_reg
        & ~(periph_en & periph_drive) & ~pin_oe_n) == 16'h0000;
  endproperty
  a_odc_all: assert property (p_odc_all)
    else $error("open drain pin driven high");

  property p_stat_clear;
    @(posedge core_clk) disable iff (!resetn)
      (stat_rd && !(|cn_chg)) |=> !st.stat;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status not cleared by read");

  property p_stat_sticky;
    @(posedge core_clk) disable iff (!resetn)
      (st.stat && !stat_rd) |=> st.stat;
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("status dropped without read");

  property p_masked_quiet;
    @(posedge core_clk) disable iff (!resetn)
      !st.mask |-> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("irq while masked");

  property p_change_sets;
    @(posedge core_clk) disable iff (!resetn)
      s_change |=> st.stat;
  endproperty
  a_change_sets: assert property (p_change_sets)
    else $error("change did not set status");

  property p_cnen_write;
    @(posedge core_clk) disable iff (!resetn)
      (st.dp_wr && st.dp_addr == OFF_CNEN_H) |=>
        cn_en[CN_W-1:16] == $past(hwdata[14:0]);
  endproperty
  a_cnen_write: assert property (p_cnen_write)
    else $error("change enable write lost");

  property p_pullup_write;
    @(posedge core_clk) disable iff (!resetn)
      (st.dp_wr && st.dp_addr == OFF_CNPU_H) |=>
        pull_up_en[CN_W-1:16] == $past(hwdata[14:0]);
  endproperty
  a_pullup_write: assert property (p_pullup_write)
    else $error("pull-up write lost");

  property p_async_quiet;
    @(posedge core_clk) disable iff (!resetn)
      (cn_en == RST_CN) |-> !cn_async_req;
  endproperty
  a_async_quiet: assert property (p_async_quiet)
    else $error("wake request with no enabled input");
endmodule : sip_port

// File: tb/sip_pin_model.sv
// pad model: resolves pin levels from port drive and outside level
`timescale 1ns/1ps
module sip_pin_model
  import sip_pkg::*;
(
  input  wire logic [sip_pkg::PIN_W-1:0] pin_out,
  input  wire logic [sip_pkg::PIN_W-1:0] pin_oe_n,
  input  wire logic [sip_pkg::PIN_W-1:0] ext_level,
  output logic      [sip_pkg::PIN_W-1:0] pin_in
);
  // driven bits follow the port, released bits the outside level
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule : sip_pin_model

// File: tb/testbench.sv
// testbench: register, pin and change tests for the shared io port
`timescale 1ns/1ps
module testbench;
  import sip_pkg::*;
  logic              core_clk, resetn, hsel, hwrite, hreadyout, hresp;
  logic              cn_async_req, irq;
  logic [31:0]       haddr, hwdata, hrdata, junk;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [PIN_W-1:0]  pin_in, pin_out, pin_oe_n, ext_level, periph_in;
  logic [PIN_W-1:0]  periph_en, periph_drive, periph_out;
  logic [CN_W-1:0]   cn, pull_up_en;
  int                err_total, total_checks;

  sip_port dut (
    .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .periph_en(periph_en),
    .periph_drive(periph_drive), .periph_out(periph_out),
    .periph_in(periph_in), .change_notify_pin(cn),
    .pull_up_en(pull_up_en), .cn_async_req(cn_async_req), .irq(irq)
  );
  sip_pin_model pads (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
    .pin_in(pin_in)
  );

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t sig got %h exp %h", $time, got, exp);
    end
  endtask : chk_sig

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, junk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000, junk);
    chk_reg(junk, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    err_total++;
    stop_test;
  end

  initial begin
    resetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h00000000;
    hwdata = 32'h00000000; htrans = 2'h0; hsize = 3'h2;
    ext_level = 16'h1200; periph_en = 16'h0000; periph_drive = 16'h0000;
    periph_out = 16'h0000; cn = 31'h00000000;
    err_total = 0; total_checks = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    idle(1);
    chk_sig(pin_oe_n, 16'hFFFF);
    rd_chk(OFF_DIR, 32'h0000FFFF);
    wr(OFF_LAT, 32'hFFFFFFFF);
    rd_chk(OFF_LAT, 32'h0000FFFF);
    wr(OFF_LAT, 32'h0000A5A5);
    rd_chk(OFF_LAT, 32'h0000A5A5);
    wr(OFF_DIR, 32'h0000FF00);
    idle(1);
    chk_sig(pin_oe_n, 16'hFF00);
    chk_sig(pin_out & 16'h00FF, 16'h00A5);
    wr(OFF_PORT, 32'h0000003C);
    rd_chk(OFF_LAT, 32'h0000003C);
    idle(4);
    rd_chk(OFF_PORT, 32'h0000123C);
    wr(OFF_ANA, 32'h00000010);
    idle(4);
    rd_chk(OFF_PORT, 32'h0000122C);
    wr(OFF_ODC, 32'h00000005);
    idle(1);
    chk_sig(pin_oe_n, 16'hFF04);
    wr(OFF_ODC, 32'h00000000);
    periph_en <= 16'h0242;
    periph_drive <= 16'h0002;
    periph_out <= 16'h0002;
    idle(4);
    chk_sig(pin_out & 16'h0042, 16'h0002);
    chk_sig(pin_oe_n, 16'hFF00);
    chk_sig(periph_in & 16'h0040, 16'h0000);
    chk_sig(periph_in & 16'h0200, 16'h0200);
    rd_chk(OFF_PORT, 32'h0000122E);
    periph_en <= 16'h0000;
    wr(OFF_CNEN_L, 32'h00000001);
    wr(OFF_MASK, 32'h00000001);
    xfer(1'b0, OFF_STAT, 32'h00000000, junk);
    cn[1] <= 1'b1;
    idle(6);
    chk_sig({15'h0000, irq}, 16'h0000);
    cn[0] <= 1'b1;
    idle(0);
    chk_sig({15'h0000, cn_async_req}, 16'h0001);
    idle(6);
    chk_sig({15'h0000, irq}, 16'h0001);
    rd_chk(OFF_STAT, 32'h00000001);
    idle(1);
    chk_sig({15'h0000, irq}, 16'h0000);
    rd_chk(OFF_STAT, 32'h00000000);
    wr(OFF_MASK, 32'h00000000);
    wr(OFF_CNEN_H, 32'h00004000);
    cn[30] <= 1'b1;
    idle(6);
    chk_sig({15'h0000, irq}, 16'h0000);
    rd_chk(OFF_STAT, 32'h00000001);
    wr(OFF_CNPU_L, 32'h00008000);
    wr(OFF_CNPU_H, 32'h00004000);
    idle(1);
    chk_reg({1'b0, pull_up_en}, 32'h40008000);
    rd_chk(OFF_CNPU_H, 32'h00004000);
    rd_chk(8'h3C, 32'h00000000);
    chk_sig({15'h0000, hresp}, 16'h0000);
    stop_test;
  end
endmodule : testbench
